// ===== hdl/vpm_mixer.sv
`timescale 1ns/1ns
`default_nettype none
`include "vpm_defines.svh"

module vpm_mixer
  import vpm_pkg::*;
#(
  parameter int SPR_W = `VPM_SPRITES * `VPM_COL_W
) (
  input wire logic clk_i,
  input wire logic reset_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`VPM_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // pixel sources
  input wire logic pix_valid_i,
  output logic pix_ready_o,
  input wire logic [SPR_W-1:0] sprite_pix_i,
  input wire logic [`VPM_COL_W-1:0] first_playfield_i,
  input wire logic [`VPM_COL_W-1:0] second_playfield_i,
  // towards colour lookup
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [3:0] out_obj_o,
  output logic [`VPM_COL_W-1:0] out_col_o
);

  localparam int BUF_W = SPR_W + 2 * `VPM_COL_W;

  // ----------------------------------------
  // priority resolution
  // ----------------------------------------
  // colour zero means no data at this position
  function automatic logic vpm_present(
    input logic [`VPM_COL_W-1:0] col
  );
    return col != `VPM_TRANSPARENT;
  endfunction

  // codes above 4 are undefined; they act as behind all pairs
  function automatic logic [`VPM_SLOT_W-1:0] vpm_slot(
    input logic [`VPM_SLOT_W-1:0] code
  );
    logic [`VPM_SLOT_W-1:0] res;
    res = code;
    if (code > `VPM_SLOT_BEHIND) begin
      res = `VPM_SLOT_BEHIND;
    end
    return res;
  endfunction

  // one sprite colour out of the packed sprite word
  function automatic logic [`VPM_COL_W-1:0] vpm_sprite_col(
    input logic [SPR_W-1:0] spr,
    input int idx
  );
    return spr[idx * `VPM_COL_W +: `VPM_COL_W];
  endfunction

  // {found, object id, colour} of one pair; even member first
  function automatic logic [8:0] vpm_pair(
    input logic [SPR_W-1:0] spr,
    input int pair
  );
    logic [`VPM_COL_W-1:0] lo;
    logic [`VPM_COL_W-1:0] hi;
    logic [8:0] res;
    lo = vpm_sprite_col(spr, 2 * pair);
    hi = vpm_sprite_col(spr, 2 * pair + 1);
    res = {1'b0, `VPM_OBJ_NONE, `VPM_TRANSPARENT};
    if (vpm_present(lo)) begin
      res = {1'b1, 4'(2 * pair), lo};
    end else if (vpm_present(hi)) begin
      res = {1'b1, 4'(2 * pair + 1), hi};
    end
    return res;
  endfunction

  // {present, object id, colour, slot} of the front playfield
  function automatic logic [11:0] vpm_front(
    input logic [`VPM_COL_W-1:0] pf1,
    input logic [`VPM_COL_W-1:0] pf2,
    input logic [`VPM_CTRL_W-1:0] ctrl
  );
    logic [11:0] res;
    res = {1'b0, `VPM_OBJ_NONE, `VPM_TRANSPARENT, `VPM_SLOT_BEHIND};
    // order bit alone decides between overlapping playfields
    if (vpm_present(pf1) && (!vpm_present(pf2) || !ctrl[`VPM_ORDER_BIT])) begin
      res = {1'b1, `VPM_OBJ_FIRST, pf1, ctrl[`VPM_FIRST_SLOT_LO +: `VPM_SLOT_W]};
    end else if (vpm_present(pf2)) begin
      res = {1'b1, `VPM_OBJ_SECOND, pf2, ctrl[`VPM_SECOND_SLOT_LO +: `VPM_SLOT_W]};
    end
    return res;
  endfunction

  // returns {object id, colour}; object 0..7 sprite, 8/9 playfields
  function automatic logic [7:0] vpm_pick(
    input logic [SPR_W-1:0] spr,
    input logic [`VPM_COL_W-1:0] pf1,
    input logic [`VPM_COL_W-1:0] pf2,
    input logic [`VPM_CTRL_W-1:0] ctrl
  );
    logic [11:0] front;
    logic [`VPM_SLOT_W-1:0] f_slot;
    logic [8:0] pair_res;
    logic [7:0] res;
    logic done;
    front = vpm_front(pf1, pf2, ctrl);
    f_slot = vpm_slot(front[2:0]);
    pair_res = {1'b0, `VPM_OBJ_NONE, `VPM_TRANSPARENT};
    res = {`VPM_OBJ_NONE, `VPM_TRANSPARENT};
    done = 1'b0;
    // five slots around four pairs: the loop runs one step past the last pair
    for (int p = 0; p <= `VPM_PAIRS; p++) begin
      // playfield sits just before pair p
      if (!done && front[11] && f_slot == p[`VPM_SLOT_W-1:0]) begin
        res = front[10:3];
        done = 1'b1;
      end
      if (p < `VPM_PAIRS) begin
        pair_res = vpm_pair(spr, p);
        // first pair with data covers all behind it
        if (!done && pair_res[8]) begin
          res = pair_res[7:0];
          done = 1'b1;
        end
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // register helpers
  // ----------------------------------------
  // address decode, shared by the read path and the error check
  function automatic logic vpm_is_ctrl(
    input logic [`VPM_ADDR_W-1:0] addr
  );
    return addr == `VPM_ADDR_CTRL;
  endfunction

  function automatic logic vpm_is_stat(
    input logic [`VPM_ADDR_W-1:0] addr
  );
    return addr == `VPM_ADDR_STAT;
  endfunction

  // status word: pixel count in the low half, last winner above it
  function automatic logic [31:0] vpm_status(
    input logic [`VPM_OBJ_W-1:0] last,
    input logic [`VPM_CNT_W-1:0] cnt
  );
    logic [31:0] res;
    res = 32'h0000_0000;
    res[`VPM_CNT_W-1:0] = cnt;
    res[`VPM_STAT_OBJ_LO +: `VPM_OBJ_W] = last;
    return res;
  endfunction

  // read word for an address; unknown addresses read zero
  function automatic logic [31:0] vpm_read_word(
    input logic [`VPM_ADDR_W-1:0] addr,
    input logic [`VPM_CTRL_W-1:0] ctrl,
    input logic [`VPM_OBJ_W-1:0] last,
    input logic [`VPM_CNT_W-1:0] cnt
  );
    logic [31:0] res;
    res = 32'h0000_0000;
    if (vpm_is_ctrl(addr)) begin
      res[`VPM_CTRL_W-1:0] = ctrl;
    end else if (vpm_is_stat(addr)) begin
      res = vpm_status(last, cnt);
    end
    return res;
  endfunction

  // only the defined control bits are kept; software holds the rest at zero
  function automatic logic [`VPM_CTRL_W-1:0] vpm_ctrl_word(
    input logic [31:0] wdata
  );
    return wdata[`VPM_CTRL_W-1:0];
  endfunction

  // ----------------------------------------
  // input buffer
  // ----------------------------------------
  logic buf_valid;
  logic buf_ready;
  logic [BUF_W-1:0] buf_data;

  // two entries let a stalled lookup hold its pixel without dropping the next
  vpm_buf #(
    .W(BUF_W)
  ) u_buf (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_valid_i(pix_valid_i),
    .in_ready_o(pix_ready_o),
    .in_data_i({sprite_pix_i, first_playfield_i, second_playfield_i}),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_ready),
    .out_data_o(buf_data)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  vpm_state_t s_r;
  vpm_state_t s_nxt;
  logic [7:0] pick;
  logic setup;
  logic access;
  logic hit_ctrl;
  logic hit_stat;
  logic drain;
  logic take_pix;

  // output register refills in the cycle it drains, keeping full rate
  assign buf_ready = !s_r.out_valid || out_ready_i;
  assign prdata_o = s_r.prdata;
  assign pready_o = s_r.pready;
  assign pslverr_o = s_r.pslverr;
  assign out_valid_o = s_r.out_valid;
  assign out_obj_o = s_r.out_obj;
  assign out_col_o = s_r.out_col;

  always_comb begin
    s_nxt = s_r;
    pick = vpm_pick(buf_data[BUF_W-1 -: SPR_W],
                    buf_data[2 * `VPM_COL_W - 1 -: `VPM_COL_W],
                    buf_data[`VPM_COL_W - 1:0],
                    s_r.ctrl);
    setup = psel_i && !penable_i;
    access = psel_i && penable_i && s_r.pready;
    hit_ctrl = vpm_is_ctrl(paddr_i);
    hit_stat = vpm_is_stat(paddr_i);

    // ----------------------------------------
    // apb: no wait states, answer prepared in setup
    // ----------------------------------------
    // every transfer gets exactly one access cycle, so ready is never held low
    s_nxt.pready = setup;
    s_nxt.pslverr = setup && !hit_ctrl && !hit_stat;
    if (setup) begin
      s_nxt.prdata = vpm_read_word(paddr_i, s_r.ctrl, s_r.last_obj, s_r.pix_cnt);
    end
    // upper bits are dropped; software keeps them at zero
    if (access && pwrite_i && hit_ctrl) begin
      s_nxt.ctrl = vpm_ctrl_word(pwdata_i);
    end

    // ----------------------------------------
    // pixel output stage
    // ----------------------------------------
    // a pixel leaves when the lookup takes it; a new one may refill the same cycle
    drain = s_r.out_valid && out_ready_i;
    take_pix = buf_valid && buf_ready;
    if (drain) begin
      s_nxt.out_valid = 1'b0;
    end
    if (take_pix) begin
      s_nxt.out_valid = 1'b1;
      s_nxt.out_obj = pick[7:4];
      s_nxt.out_col = pick[3:0];
      s_nxt.last_obj = pick[7:4];
      s_nxt.pix_cnt = s_r.pix_cnt + `VPM_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_r <= '0;
      // no winner yet after reset; status reads object none
      s_r.ctrl <= `VPM_CTRL_RST;
      s_r.out_obj <= `VPM_OBJ_NONE;
      s_r.last_obj <= `VPM_OBJ_NONE;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

`default_nettype wire

// ===== hdl/vpm_defines.svh
`ifndef VPM_DEFINES_SVH
`define VPM_DEFINES_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define VPM_ADDR_W 12
`define VPM_ADDR_CTRL 12'h000
`define VPM_ADDR_STAT 12'h004
`define VPM_STAT_OBJ_LO 16
`define VPM_OBJ_W 4

// ----------------------------------------
// priority control fields
// ----------------------------------------
`define VPM_CTRL_W 7
`define VPM_CTRL_RST 7'h00
`define VPM_FIRST_SLOT_LO 0
`define VPM_SECOND_SLOT_LO 3
`define VPM_SLOT_W 3
`define VPM_ORDER_BIT 6
`define VPM_SLOT_BEHIND 3'h4

// ----------------------------------------
// pixel stream
// ----------------------------------------
`define VPM_SPRITES 8
`define VPM_PAIRS 4
`define VPM_COL_W 4
`define VPM_TRANSPARENT 4'h0
`define VPM_OBJ_FIRST 4'h8
`define VPM_OBJ_SECOND 4'h9
`define VPM_OBJ_NONE 4'hf
`define VPM_CNT_W 16

`endif

// ===== hdl/vpm_pkg.sv
`include "vpm_defines.svh"

package vpm_pkg;

  typedef struct packed {
    logic [`VPM_CTRL_W-1:0] ctrl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic out_valid;
    logic [3:0] out_obj;
    logic [`VPM_COL_W-1:0] out_col;
    logic [3:0] last_obj;
    logic [`VPM_CNT_W-1:0] pix_cnt;
  } vpm_state_t;

endpackage

// ===== hdl/vpm_buf.sv
`timescale 1ns/1ns
`default_nettype none

// two-entry buffer; in_ready_o is registered so the source never sees a comb path
module vpm_buf #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  typedef struct packed {
    logic [W-1:0] e0;
    logic [W-1:0] e1;
    logic [1:0] cnt;
    logic in_ready;
  } vpm_buf_t;

  vpm_buf_t s_r;
  vpm_buf_t s_nxt;
  logic push;
  logic pop;

  assign in_ready_o = s_r.in_ready;
  assign out_valid_o = (s_r.cnt != 2'h0);
  assign out_data_o = s_r.e0;

  always_comb begin
    s_nxt = s_r;
    push = in_valid_i && s_r.in_ready;
    pop = out_valid_o && out_ready_i;
    if (pop) begin
      s_nxt.e0 = s_r.e1;
    end
    case ({push, pop})
      2'b10: begin
        if (s_r.cnt == 2'h0) begin
          s_nxt.e0 = in_data_i;
        end else begin
          s_nxt.e1 = in_data_i;
        end
        s_nxt.cnt = s_r.cnt + 2'h1;
      end
      2'b01: begin
        s_nxt.cnt = s_r.cnt - 2'h1;
      end
      2'b11: begin
        // none left after the pop lands in e0, else the new word goes behind the one left
        if (s_r.cnt == 2'h1) begin
          s_nxt.e0 = in_data_i;
        end else begin
          s_nxt.e1 = in_data_i;
        end
      end
      default: begin
        s_nxt.cnt = s_r.cnt;
      end
    endcase
    s_nxt.in_ready = (s_nxt.cnt != 2'h2);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_r <= '0;
      s_r.in_ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

`default_nettype wire

// ===== verif/vpm_mixer_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module vpm_mixer_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [11:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic pix_valid_i,
  input wire logic pix_ready_o,
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire logic [3:0] out_obj_o,
  input wire logic [3:0] out_col_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic acc;
  assign acc = psel_i & penable_i & pready_o;
  property p_apb; psel_i && !penable_i |=> pready_o; endproperty
  a_apb: assert property (p_apb) else $error("no access answer");
  property p_err; acc |-> pslverr_o == !(paddr_i inside {12'h000, 12'h004}); endproperty
  a_err: assert property (p_err) else $error("bad error code");
  property p_pulse; pready_o |=> !pready_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_erp; pslverr_o |-> pready_o; endproperty
  a_erp: assert property (p_erp) else $error("error without ready");
  // a stalled pixel must not change under the lookup
  property p_hold; out_valid_o && !out_ready_i |=> out_valid_o && $stable({out_obj_o, out_col_o}); endproperty
  a_hold: assert property (p_hold) else $error("output changed in stall");
  property p_none; out_valid_o && out_obj_o == 4'hf |-> out_col_o == 4'h0; endproperty
  a_none: assert property (p_none) else $error("colour without object");
  property p_win; out_valid_o && out_obj_o != 4'hf |-> out_col_o != 4'h0; endproperty
  a_win: assert property (p_win) else $error("transparent winner");
  property p_id; out_valid_o |-> out_obj_o <= 4'h9 || out_obj_o == 4'hf; endproperty
  a_id: assert property (p_id) else $error("bad object id");
  property p_lat; pix_valid_i && pix_ready_o && !out_valid_o |-> ##[1:3] out_valid_o; endproperty
  a_lat: assert property (p_lat) else $error("pixel lost");
  c_stall: cover property (out_valid_o && !out_ready_i);
  c_full: cover property (pix_valid_i && !pix_ready_o);
  c_bad: cover property (pslverr_o);
  c_pf2: cover property (out_valid_o && out_obj_o == 4'h9);
endmodule
bind vpm_mixer vpm_mixer_checker u_chk (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
  .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o), .out_valid_o(out_valid_o),
  .out_ready_i(out_ready_i), .out_obj_o(out_obj_o), .out_col_o(out_col_o));
`default_nettype wire

// ===== verif/vpm_pix_src.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// pixel source model
// ----------------------------------------
module vpm_pix_src (
  input wire logic clk_i,
  input wire logic ready_i,
  output var logic valid_o,
  output var logic [31:0] spr_o,
  output var logic [3:0] pf1_o,
  output var logic [3:0] pf2_o
);
  initial begin
    valid_o = 1'b0;
    spr_o = 32'h0;
    pf1_o = 4'h0;
    pf2_o = 4'h0;
  end
  task automatic send(input logic [31:0] s, input logic [3:0] a, input logic [3:0] b, input int gap);
    valid_o <= 1'b1;
    spr_o <= s;
    pf1_o <= a;
    pf2_o <= b;
    do @(posedge clk_i); while (ready_i !== 1'b1);
    if (gap > 0) begin
      // released lines show junk, never the stale word
      valid_o <= 1'b0;
      spr_o <= ~s;
      pf1_o <= ~a;
      pf2_o <= ~b;
      repeat (gap) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ===== verif/video_priority_mixer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module video_priority_mixer_tb_top;
  logic clk_i = 0, reset_i = 1, psel = 0, penable = 0, pwrite = 0, out_rdy = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, spr, s;
  logic pready, pslverr, er, pv, pr, ov;
  logic [3:0] f1, f2, obj, col, a, b, last = 4'hf;
  logic [6:0] ctrl;
  int miscompares = 0, cmp_count = 0, seed = 32'h5d87, n = 0, i, k, e, q[$];
  initial forever #2 clk_i = ~clk_i;
  vpm_pix_src src (.clk_i(clk_i), .ready_i(pr), .valid_o(pv), .spr_o(spr), .pf1_o(f1), .pf2_o(f2));
  vpm_mixer #(.SPR_W(32)) dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .pix_valid_i(pv), .pix_ready_o(pr), .sprite_pix_i(spr), .first_playfield_i(f1),
    .second_playfield_i(f2), .out_valid_o(ov), .out_ready_i(out_rdy), .out_obj_o(obj), .out_col_o(col));
  // ----------------------------------------
  // reference model and tasks
  // ----------------------------------------
  function automatic int win(logic [31:0] sp, logic [3:0] p1, logic [3:0] p2, logic [6:0] c);
    int fs, fo, fc, j;
    fo = 8;
    fc = p1;
    fs = c[2:0];
    if (p1 == 0 || (c[6] && p2 != 0)) begin
      fo = 9;
      fc = p2;
      fs = c[5:3];
    end
    if (fs > 4) fs = 4;
    for (j = 0; j < 8; j++)
      if (sp[4*j+:4] != 0 && (fc == 0 || j / 2 < fs)) return j * 16 + sp[4*j+:4];
    if (fc != 0) return fo * 16 + fc;
    return 8'hf0;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic chk_pix(input logic [3:0] o, input logic [3:0] c, input int x);
    cmp_count++;
    if ({o, c} !== x[7:0]) begin
      miscompares++;
      $display("CHECK FAILED t=%0t pixel got %h%h exp %h", $time, o, c, x[7:0]);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_i) out_rdy <= $random(seed) % 2 != 0;
  always @(posedge clk_i) if (ov === 1'b1 && out_rdy === 1'b1 && !reset_i) begin
    // a pixel with nothing queued meets object none with a nonzero colour, which no pixel can carry
    e = (q.size() > 0) ? q.pop_front() : -1;
    chk_pix(obj, col, e);
    last = e[7:4];
    n++;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    end_of_test;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 0;
    apb(0, 12'h000, 0);
    chk(rd, 32'h0);
    apb(0, 12'h008, 0);
    chk({31'h0, er}, 32'h1);
    apb(1, 12'h000, 32'h0000007f);
    apb(0, 12'h000, 0);
    chk(rd, 32'h7f);
    $display("register test done");
    for (i = 0; i < 16; i++) begin
      ctrl = {i[3], 3'(i * 3), 3'(i)};
      apb(1, 12'h000, {25'h0, ctrl});
      for (k = 0; k < 20; k++) begin
        s = $random(seed) & $random(seed);
        a = 4'($random(seed) & $random(seed));
        b = 4'($random(seed) & $random(seed));
        // first words of each test: nothing at all, then playfields alone
        if (k < 2) s = 32'h0;
        if (k == 0) begin
          a = 4'h0;
          b = 4'h0;
        end
        q.push_back(win(s, a, b, ctrl));
        // last word is released so it is not taken twice
        src.send(s, a, b, k == 19 ? 1 : {$random(seed)} % 3);
      end
      while (q.size() > 0) @(posedge clk_i);
      $display("test %0d done", i);
    end
    apb(0, 12'h004, 0);
    chk(rd, {12'h0, last, 16'(n)});
    end_of_test;
  end
endmodule
`default_nettype wire
